// ==== design/nmi_fault_pkg.sv ====
// package: register map, field layout, timing and carrier types of the nmi/fault/enable block
package nmi_fault_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // clock and timing
   localparam int unsigned CLK_FREQ_HZ = 100_000_000;
   localparam int unsigned WDOG_LOW_WATER_MS = 1792; // nominal low-water time, 1.792 s
   localparam int unsigned WDOG_LOW_WATER_CYCLES = WDOG_LOW_WATER_MS * (CLK_FREQ_HZ / 1000);
   localparam int unsigned WDOG_CNT_W = 28;

   ////////////////////////////////////////////////////////////////////////////////
   // register byte addresses
   localparam logic [31:0] ADDR_IRQ_ENABLE_SET = 32'hE000_E100;
   localparam logic [31:0] ADDR_IRQ_ENABLE_CLEAR = 32'hE000_E180;
   localparam logic [31:0] ADDR_IRQ_PENDING_SET = 32'hE000_E200;
   localparam logic [31:0] ADDR_AUX_FAULT_STATUS = 32'hE000_E500;
   localparam logic [31:0] ADDR_NMI_FLAG = 32'hE000_E504;
   localparam logic [31:0] ADDR_NMI_CFG = 32'hE000_E508;
   localparam logic [31:0] ADDR_NMI_MISSED = 32'hE000_E50C;
   localparam logic [31:0] ADDR_WDOG_CTRL = 32'hE000_E510;
   localparam logic [31:0] ADDR_CLOCK_CTRL = 32'hE000_E514;

   ////////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [31:0] RST_IRQ_ENABLE = 32'h0000_0000;
   localparam logic [1:0] RST_NMI_CFG = 2'h3;

   ////////////////////////////////////////////////////////////////////////////////
   // field layout
   // implemented top-level sources: 16,15,14,12,10,9,8,7,5,4,3,2
   localparam logic [31:0] IRQ_SRC_MASK = 32'h0001_D7BC;
   localparam int unsigned NMI_BIT_CRYSTAL = 0;  // crystal_fail_event
   localparam int unsigned NMI_BIT_WDOG = 1;     // watchdog low-water event
   localparam int unsigned FAULT_BIT_WIDTH = 0;  // bad_width_fault
   localparam int unsigned FAULT_BIT_PRIV = 1;
   localparam int unsigned FAULT_BIT_UNMAPPED = 2;
   localparam int unsigned FAULT_BIT_REPEAT = 3;
   localparam int unsigned WDOG_BIT_ACTIVE = 0;
   localparam int unsigned WDOG_BIT_RESTART = 1;
   localparam int unsigned CLK_BIT_ON_RC = 0;
   localparam int unsigned CLK_BIT_RETURN = 1;

   ////////////////////////////////////////////////////////////////////////////////
   // bus response codes and access sizes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] SIZE_WORD = 2'h2;

   ////////////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [1:0] {
      XTAL_RUN = 2'b00,
      XTAL_SWITCH = 2'b01,
      XTAL_ON_RC = 2'b10
   } xtal_state_e;

   // one observed access on the system buses, valid for one cycle
   typedef struct packed {
      logic valid;
      logic write;
      logic user_mode;      // unprivileged access
      logic [1:0] size;     // 0 byte, 1 half, 2 word
      logic [1:0] addr_lo;  // low address bits
      logic periph_bus;     // targets a peripheral-bus register
      logic system_periph;  // targets a system peripheral on either bus
      logic protected_ram;
      logic above_last_reg; // inside a 4 kB block, above its last register
      logic above_mem_top;  // above top of ram or flash
   } bus_access_s;

   typedef struct packed {
      logic repeat_f;
      logic unmapped;
      logic privilege;
      logic width;
   } fault_bits_s;

endpackage

// ==== design/wdog_low_water.sv ====
// watchdog low-water timer: one pulse after a full period without restart
module wdog_low_water
   import nmi_fault_pkg::*;
#(
   parameter int unsigned CYCLES = WDOG_LOW_WATER_CYCLES
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // control
   input wire logic active,
   input wire logic restart,
   // event
   output logic low_water_q
);

   logic [WDOG_CNT_W-1:0] cnt_q;
   logic expired_q;

   ////////////////////////////////////////////////////////////////////////////////
   // count while active; restart or idle rearms
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= '0;
         expired_q <= 1'b0;
         low_water_q <= 1'b0;
      end else if (!active || restart) begin
         cnt_q <= '0;
         expired_q <= 1'b0;
         low_water_q <= 1'b0;
      end else if (!expired_q && cnt_q == WDOG_CNT_W'(CYCLES - 1)) begin
         expired_q <= 1'b1;
         low_water_q <= 1'b1;
      end else begin
         if (!expired_q) begin
            cnt_q <= cnt_q + 1'b1;
         end
         low_water_q <= 1'b0;
      end
   end

endmodule

// ==== design/nmi_fault_irq_enable_ctrl.sv ====
// nmi sourcing, bus fault cause recording and top-level irq enables, axi4-lite slave
// Summary of operation
// - nmi comes from two second-level flags only: crystal failure and watchdog low water
// - crystal failure while running on crystal switches the main clock to the rc oscillator
// - crystal fail event rises only after the switch is done, then drives nmi
// - active watchdog not restarted for 1.792 s raises low-water event driving nmi
// - bus fault causes are separate sticky bits; one access may set several
// - width fault: byte or half access to peripheral bus, or unaligned word access
// - privilege fault: user write to system peripheral or protected ram
// - unmapped fault: above last register of a 4 kB block, or above memory top
// - repeat-fault bit set when a second bus fault arrives
// - writing 1 to enable-set enables that source; 0 does nothing; reserved read 0
// - writing 1 to enable-clear disables that source; 0 does nothing
// - all top-level enables are zero after reset
// - writing 1 to pending-set pends that source; 0 does nothing
// - second-level lines are levels; nmi holds until every enabled flag is cleared
// - enabled repeat event while flag set is not queued but logged in missed register, w1c
module nmi_fault_irq_enable_ctrl
   import nmi_fault_pkg::*;
#(
   parameter int unsigned WDOG_CYCLES = WDOG_LOW_WATER_CYCLES
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] awaddr,
   input wire logic [2:0] awprot,
   // axi4-lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // axi4-lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi4-lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [31:0] araddr,
   input wire logic [2:0] arprot,
   // axi4-lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // clock monitor
   input wire logic crystal_ok,
   output logic clk_sel_rc_q,
   // observed bus accesses
   input wire bus_access_s bus_access,
   output logic bus_fault_q,
   // to the core interrupt controller
   output logic nmi_q,
   output logic [31:0] irq_enable_q,
   output logic [31:0] irq_pend_pulse_q
);

   ////////////////////////////////////////////////////////////////////////////////
   // declarations
   logic aw_have_q, w_have_q, aw_ready_q, w_ready_q, b_valid_q, ar_ready_q, r_valid_q;
   logic [1:0] b_resp_q, r_resp_q;
   logic [31:0] aw_addr_q, w_data_q, r_data_q;
   logic [3:0] w_strb_q;
   logic wr_en;
   logic [31:0] wr_ones;
   logic wr_hit;
   logic [31:0] rd_val;
   logic rd_hit;
   logic [1:0] nmi_flag_q, nmi_cfg_q, nmi_missed_q;
   logic [1:0] nmi_event;
   fault_bits_s fault_q, fault_now;
   logic fault_any;
   logic wdog_active_q, wdog_restart_q, wdog_event;
   logic crystal_event_q;
   xtal_state_e xtal_q;

   ////////////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [31:0] lane_mask(input logic [3:0] strb);
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = {8{strb[i]}};
      end
      return m;
   endfunction

   function automatic logic is_mapped(input logic [31:0] a);
      return a == ADDR_IRQ_ENABLE_SET || a == ADDR_IRQ_ENABLE_CLEAR ||
             a == ADDR_IRQ_PENDING_SET || a == ADDR_AUX_FAULT_STATUS ||
             a == ADDR_NMI_FLAG || a == ADDR_NMI_CFG || a == ADDR_NMI_MISSED ||
             a == ADDR_WDOG_CTRL || a == ADDR_CLOCK_CTRL;
   endfunction

   // ones written to a register this cycle, per byte lane
   function automatic logic [31:0] ones_to(input logic [31:0] a);
      return (wr_en && aw_addr_q == a) ? (w_data_q & lane_mask(w_strb_q)) : 32'h0000_0000;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // write address and data capture, either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         aw_ready_q <= 1'b0;
         aw_addr_q <= 32'h0000_0000;
      end else if (awvalid && aw_ready_q) begin
         aw_have_q <= 1'b1;
         aw_ready_q <= 1'b0;
         aw_addr_q <= awaddr;
      end else if (wr_en) begin
         aw_have_q <= 1'b0;
         aw_ready_q <= 1'b1;
      end else begin
         aw_ready_q <= !aw_have_q;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_have_q <= 1'b0;
         w_ready_q <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end else if (wvalid && w_ready_q) begin
         w_have_q <= 1'b1;
         w_ready_q <= 1'b0;
         w_data_q <= wdata;
         w_strb_q <= wstrb;
      end else if (wr_en) begin
         w_have_q <= 1'b0;
         w_ready_q <= 1'b1;
      end else begin
         w_ready_q <= !w_have_q;
      end
   end

   // commit once both halves held and previous response gone
   assign wr_en = aw_have_q && w_have_q && !b_valid_q;
   assign wr_hit = is_mapped(aw_addr_q);

   ////////////////////////////////////////////////////////////////////////////////
   // write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         b_valid_q <= 1'b0;
         b_resp_q <= RESP_OKAY;
      end else if (wr_en) begin
         b_valid_q <= 1'b1;
         b_resp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (b_valid_q && bready) begin
         b_valid_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read mux, no read side effects
   always_comb begin
      rd_val = 32'h0000_0000;
      rd_hit = 1'b1;
      unique case (araddr)
         ADDR_IRQ_ENABLE_SET: rd_val = irq_enable_q;
         ADDR_IRQ_ENABLE_CLEAR: rd_val = irq_enable_q;
         ADDR_IRQ_PENDING_SET: rd_val = 32'h0000_0000;
         ADDR_AUX_FAULT_STATUS: rd_val = {28'h0000000, fault_q};
         ADDR_NMI_FLAG: rd_val = {30'h0, nmi_flag_q};
         ADDR_NMI_CFG: rd_val = {30'h0, nmi_cfg_q};
         ADDR_NMI_MISSED: rd_val = {30'h0, nmi_missed_q};
         ADDR_WDOG_CTRL: rd_val = {31'h0, wdog_active_q};
         ADDR_CLOCK_CTRL: rd_val = {31'h0, clk_sel_rc_q};
         default: rd_hit = 1'b0;
      endcase
   end

   // read channel: data one cycle after address taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ar_ready_q <= 1'b0;
         r_valid_q <= 1'b0;
         r_data_q <= 32'h0000_0000;
         r_resp_q <= RESP_OKAY;
      end else if (arvalid && ar_ready_q) begin
         ar_ready_q <= 1'b0;
         r_valid_q <= 1'b1;
         r_data_q <= rd_val;
         r_resp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (r_valid_q && rready) begin
         r_valid_q <= 1'b0;
         ar_ready_q <= 1'b1;
      end else begin
         ar_ready_q <= !r_valid_q;
      end
   end

   assign awready = aw_ready_q;
   assign wready = w_ready_q;
   assign bvalid = b_valid_q;
   assign bresp = b_resp_q;
   assign arready = ar_ready_q;
   assign rvalid = r_valid_q;
   assign rdata = r_data_q;
   assign rresp = r_resp_q;

   ////////////////////////////////////////////////////////////////////////////////
   // top-level enables: set then clear, so clear wins
   assign wr_ones = ones_to(ADDR_IRQ_ENABLE_SET);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_enable_q <= RST_IRQ_ENABLE;
      end else begin
         irq_enable_q <= (irq_enable_q | (wr_ones & IRQ_SRC_MASK))
                         & ~(ones_to(ADDR_IRQ_ENABLE_CLEAR) & IRQ_SRC_MASK);
      end
   end

   // software pend request, one-cycle pulse per source
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_pend_pulse_q <= 32'h0000_0000;
      end else begin
         irq_pend_pulse_q <= ones_to(ADDR_IRQ_PENDING_SET) & IRQ_SRC_MASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // crystal monitor and clock fallback
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         xtal_q <= XTAL_RUN;
         clk_sel_rc_q <= 1'b0;
         crystal_event_q <= 1'b0;
      end else begin
         crystal_event_q <= 1'b0;
         unique case (xtal_q)
            XTAL_RUN: begin
               if (!crystal_ok) begin
                  clk_sel_rc_q <= 1'b1;
                  xtal_q <= XTAL_SWITCH;
               end
            end
            XTAL_SWITCH: begin
               crystal_event_q <= 1'b1;
               xtal_q <= XTAL_ON_RC;
            end
            XTAL_ON_RC: begin
               if (crystal_ok && 1'(ones_to(ADDR_CLOCK_CTRL) >> CLK_BIT_RETURN)) begin
                  clk_sel_rc_q <= 1'b0;
                  xtal_q <= XTAL_RUN;
               end
            end
            default: begin
               xtal_q <= XTAL_ON_RC;
               clk_sel_rc_q <= 1'b1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // watchdog control and timer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wdog_active_q <= 1'b0;
         wdog_restart_q <= 1'b0;
      end else begin
         if (wr_en && aw_addr_q == ADDR_WDOG_CTRL && w_strb_q[0]) begin
            wdog_active_q <= w_data_q[WDOG_BIT_ACTIVE];
         end
         wdog_restart_q <= 1'(ones_to(ADDR_WDOG_CTRL) >> WDOG_BIT_RESTART);
      end
   end

   wdog_low_water #(
      .CYCLES(WDOG_CYCLES)
   ) u_wdog (
      .aclk(aclk),
      .aresetn(aresetn),
      .active(wdog_active_q),
      .restart(wdog_restart_q),
      .low_water_q(wdog_event)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // second-level nmi flags, mask and missed log
   always_comb begin
      nmi_event = '0;
      nmi_event[NMI_BIT_CRYSTAL] = crystal_event_q;
      nmi_event[NMI_BIT_WDOG] = wdog_event;
   end

   // flags always record; set wins over a same-cycle clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         nmi_flag_q <= 2'h0;
      end else begin
         nmi_flag_q <= (nmi_flag_q & ~2'(ones_to(ADDR_NMI_FLAG))) | nmi_event;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         nmi_cfg_q <= RST_NMI_CFG;
      end else if (wr_en && aw_addr_q == ADDR_NMI_CFG && w_strb_q[0]) begin
         nmi_cfg_q <= w_data_q[1:0];
      end
   end

   // enabled repeat while flag still set is lost, logged here
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         nmi_missed_q <= 2'h0;
      end else begin
         nmi_missed_q <= (nmi_missed_q & ~2'(ones_to(ADDR_NMI_MISSED)))
                         | (nmi_event & nmi_flag_q & nmi_cfg_q);
      end
   end

   // level output, held until every enabled flag cleared
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         nmi_q <= 1'b0;
      end else begin
         nmi_q <= |(nmi_flag_q & nmi_cfg_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // bus fault cause decode
   always_comb begin
      fault_now = '0;
      if (bus_access.valid) begin
         fault_now.width = (bus_access.periph_bus && bus_access.size != SIZE_WORD)
                           || (bus_access.size == SIZE_WORD && bus_access.addr_lo != 2'h0);
         fault_now.privilege = bus_access.write && bus_access.user_mode
                               && (bus_access.system_periph || bus_access.protected_ram);
         fault_now.unmapped = bus_access.above_last_reg || bus_access.above_mem_top;
      end
   end

   assign fault_any = fault_now.width || fault_now.privilege || fault_now.unmapped;

   // sticky causes, several per access; w1c with set winning
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fault_q <= '0;
      end else begin
         fault_q <= (fault_q & ~fault_bits_s'(4'(ones_to(ADDR_AUX_FAULT_STATUS))))
                    | fault_now
                    | {fault_any && (fault_q != '0), 3'b000};
      end
   end

   // one-cycle fault pulse toward the core
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bus_fault_q <= 1'b0;
      end else begin
         bus_fault_q <= fault_any;
      end
   end

endmodule

// ==== tb/nmi_fault_checker.sv ====
// port-level assertions for the nmi, fault and enable block
module nmi_fault_checker
   import nmi_fault_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // observed ports
   input wire logic bvalid,
   input wire logic crystal_ok,
   input wire logic clk_sel_rc_q,
   input wire bus_access_s bus_access,
   input wire logic bus_fault_q,
   input wire logic nmi_q,
   input wire logic [31:0] irq_enable_q
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // enable register
   AST_ENABLE_RESET: assert property ($rose(aresetn) |-> irq_enable_q == 32'h0)
      else $error("enables not zero after reset");
   AST_RESERVED_ZERO: assert property ((irq_enable_q & ~IRQ_SRC_MASK) == 32'h0)
      else $error("reserved enable bit set");
   AST_ENABLE_BY_WRITE: assert property ($changed(irq_enable_q) |-> $rose(bvalid))
      else $error("enables changed without a write response");
   // clock fallback and nmi
   AST_XTAL_SWITCH: assert property (!crystal_ok && !clk_sel_rc_q |=> clk_sel_rc_q)
      else $error("no switch to rc after crystal loss");
   AST_XTAL_NMI: assert property ($rose(clk_sel_rc_q) |-> ##3 nmi_q)
      else $error("nmi missing after clock switch");
   AST_NMI_HOLD: assert property ($rose(nmi_q) |-> nmi_q [*3])
      else $error("nmi dropped early");
   // bus fault causes
   AST_WIDTH: assert property (bus_access.valid && ((bus_access.periph_bus
      && bus_access.size != SIZE_WORD) || (bus_access.size == SIZE_WORD
      && bus_access.addr_lo != 2'h0)) |=> bus_fault_q)
      else $error("width fault not flagged");
   AST_PRIV: assert property (bus_access.valid && bus_access.write && bus_access.user_mode
      && (bus_access.system_periph || bus_access.protected_ram) |=> bus_fault_q)
      else $error("privilege fault not flagged");
   AST_UNMAPPED: assert property (bus_access.valid
      && (bus_access.above_last_reg || bus_access.above_mem_top) |=> bus_fault_q)
      else $error("unmapped fault not flagged");
   AST_NO_CAUSE: assert property (!bus_access.valid |=> !bus_fault_q)
      else $error("fault without an access");
endmodule

bind nmi_fault_irq_enable_ctrl nmi_fault_checker u_chk (
   .aclk(aclk), .aresetn(aresetn), .bvalid(bvalid), .crystal_ok(crystal_ok),
   .clk_sel_rc_q(clk_sel_rc_q), .bus_access(bus_access), .bus_fault_q(bus_fault_q),
   .nmi_q(nmi_q), .irq_enable_q(irq_enable_q)
);

// ==== tb/core_irq_model.sv ====
// core side model: gathers pend requests and counts nmi entries
module core_irq_model (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // from the block
   input wire logic nmi_q,
   input wire logic [31:0] irq_pend_pulse_q,
   // observations
   output logic [31:0] pend_seen_q,
   output logic [31:0] nmi_count_q
);
   timeunit 1ns;
   timeprecision 1ps;
   logic nmi_last_q;
   // record pend pulses and nmi rising edges
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pend_seen_q <= 32'h0;
         nmi_count_q <= 32'h0;
         nmi_last_q <= 1'b0;
      end else begin
         pend_seen_q <= pend_seen_q | irq_pend_pulse_q;
         nmi_count_q <= nmi_count_q + {31'h0, nmi_q & ~nmi_last_q};
         nmi_last_q <= nmi_q;
      end
   end
endmodule

// ==== tb/nmi_fault_irq_enable_ctrl_test.sv ====
// self-checking bench for the nmi, fault and enable block
module nmi_fault_irq_enable_ctrl_test
   import nmi_fault_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned WD_CYC = 20;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, crystal_ok, clk_sel_rc_q, bus_fault_q, nmi_q;
   logic [31:0] awaddr, wdata, araddr, rdata, irq_enable_q, irq_pend_pulse_q;
   logic [31:0] pend_seen_q, nmi_count_q;
   logic [3:0] wstrb;
   logic [2:0] awprot, arprot;
   logic [1:0] bresp, rresp;
   bus_access_s bus_access;
   int n_fail, cmp_count;
   ////////////////////////////////////////////////////////////
   // block and core model
   nmi_fault_irq_enable_ctrl #(.WDOG_CYCLES(WD_CYC)) u_dut (
      .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .awprot(awprot), .wvalid(wvalid), .wready(wready), .wdata(wdata),
      .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .arprot(arprot), .rvalid(rvalid),
      .rready(rready), .rdata(rdata), .rresp(rresp), .crystal_ok(crystal_ok),
      .clk_sel_rc_q(clk_sel_rc_q), .bus_access(bus_access), .bus_fault_q(bus_fault_q),
      .nmi_q(nmi_q), .irq_enable_q(irq_enable_q), .irq_pend_pulse_q(irq_pend_pulse_q));
   core_irq_model u_core (.aclk(aclk), .aresetn(aresetn), .nmi_q(nmi_q),
      .irq_pend_pulse_q(irq_pend_pulse_q), .pend_seen_q(pend_seen_q),
      .nmi_count_q(nmi_count_q));
   ////////////////////////////////////////////////////////////
   // compare and report
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // bus master cycles
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) begin
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            wvalid <= 1'b0;
         end
         if (bready && bvalid) begin
            bready <= 1'b0;
            chk(32'(bresp), 32'(er));
         end
      end while (awvalid || wvalid || bready);
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) begin
            arvalid <= 1'b0;
         end
         if (rready && rvalid) begin
            rready <= 1'b0;
            chk(rdata, e);
            chk(32'(rresp), 32'(er));
         end
      end while (arvalid || rready);
   endtask
   task automatic do_reset();
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
   endtask
   ////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_enable();
      logic [31:0] e;
      rd(ADDR_IRQ_ENABLE_SET, RST_IRQ_ENABLE, RESP_OKAY);
      wr(ADDR_IRQ_ENABLE_SET, 32'hFFFF_FFFF, RESP_OKAY);
      rd(ADDR_IRQ_ENABLE_SET, IRQ_SRC_MASK, RESP_OKAY);
      rd(ADDR_IRQ_ENABLE_CLEAR, IRQ_SRC_MASK, RESP_OKAY);
      wr(ADDR_IRQ_ENABLE_CLEAR, 32'h0, RESP_OKAY);
      wr(ADDR_IRQ_ENABLE_SET, 32'h0, RESP_OKAY);
      chk(irq_enable_q, IRQ_SRC_MASK);
      e = IRQ_SRC_MASK;
      for (int i = 0; i < 32; i++) begin
         wr(ADDR_IRQ_ENABLE_CLEAR, 32'h1 << i, RESP_OKAY);
         e[i] = 1'b0;
         chk(irq_enable_q, e);
      end
      wr(ADDR_IRQ_ENABLE_SET, 32'h0000_8004, RESP_OKAY);
      wr(ADDR_IRQ_ENABLE_SET + 32'h4, 32'hFFFF_FFFF, RESP_SLVERR);
      rd(ADDR_IRQ_ENABLE_SET + 32'h4, 32'h0, RESP_SLVERR);
      rd(ADDR_IRQ_ENABLE_CLEAR, 32'h0000_8004, RESP_OKAY);
      do_reset();
      chk(irq_enable_q, RST_IRQ_ENABLE);
   endtask
   task automatic t_pend();
      wr(ADDR_IRQ_PENDING_SET, 32'h0000_0104, RESP_OKAY);
      wr(ADDR_IRQ_PENDING_SET, 32'h0, RESP_OKAY);
      chk(pend_seen_q, 32'h0000_0104);
      rd(ADDR_IRQ_PENDING_SET, 32'h0, RESP_OKAY);
      chk(irq_enable_q, 32'h0);
   endtask
   task automatic t_crystal();
      logic [31:0] c0;
      c0 = nmi_count_q;
      crystal_ok <= 1'b0;
      // switch, event, flag, then nmi: one edge each
      repeat (5) @(posedge aclk);
      chk(32'(clk_sel_rc_q), 32'h1);
      chk(32'(nmi_q), 32'h1);
      rd(ADDR_NMI_FLAG, 32'h1, RESP_OKAY);
      crystal_ok <= 1'b1;
      wr(ADDR_CLOCK_CTRL, 32'h2, RESP_OKAY);
      chk(32'(clk_sel_rc_q), 32'h0);
      chk(32'(nmi_q), 32'h1);
      wr(ADDR_NMI_FLAG, 32'h1, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk(32'(nmi_q), 32'h0);
      chk(nmi_count_q, c0 + 32'h1);
   endtask
   task automatic t_wdog();
      wr(ADDR_WDOG_CTRL, 32'h1, RESP_OKAY);
      repeat (12) @(posedge aclk);
      chk(32'(nmi_q), 32'h0);
      wr(ADDR_WDOG_CTRL, 32'h3, RESP_OKAY);
      repeat (12) @(posedge aclk);
      chk(32'(nmi_q), 32'h0);
      repeat (20) @(posedge aclk);
      chk(32'(nmi_q), 32'h1);
      rd(ADDR_NMI_FLAG, 32'h2, RESP_OKAY);
      // second expiry while the flag still stands is only logged
      wr(ADDR_WDOG_CTRL, 32'h3, RESP_OKAY);
      repeat (30) @(posedge aclk);
      rd(ADDR_NMI_MISSED, 32'h2, RESP_OKAY);
      wr(ADDR_NMI_MISSED, 32'h2, RESP_OKAY);
      rd(ADDR_NMI_MISSED, 32'h0, RESP_OKAY);
      // masking drops nmi while the flag keeps recording
      wr(ADDR_NMI_CFG, 32'h1, RESP_OKAY);
      chk(32'(nmi_q), 32'h0);
      rd(ADDR_NMI_FLAG, 32'h2, RESP_OKAY);
      wr(ADDR_NMI_CFG, 32'h3, RESP_OKAY);
      chk(32'(nmi_q), 32'h1);
      wr(ADDR_WDOG_CTRL, 32'h0, RESP_OKAY);
      wr(ADDR_NMI_FLAG, 32'h2, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk(32'(nmi_q), 32'h0);
   endtask
   task automatic fault(input logic [11:0] v, input logic clr, input logic [31:0] e);
      if (clr) begin
         wr(ADDR_AUX_FAULT_STATUS, 32'hF, RESP_OKAY);
      end
      bus_access <= bus_access_s'(v);
      @(posedge aclk);
      bus_access <= '0;
      @(posedge aclk);
      chk(32'(bus_fault_q), 32'(e != 32'h0));
      rd(ADDR_AUX_FAULT_STATUS, e, RESP_OKAY);
      chk(32'(nmi_q), 32'h0);
   endtask
   task automatic t_fault();
      fault(12'hD10, 1'b1, 32'h0);
      fault(12'h810, 1'b1, 32'h1);
      fault(12'hC90, 1'b1, 32'h1);
      fault(12'h920, 1'b1, 32'h1);
      fault(12'hF08, 1'b1, 32'h2);
      fault(12'hF04, 1'b1, 32'h2);
      fault(12'hB08, 1'b1, 32'h0);
      fault(12'h912, 1'b1, 32'h4);
      fault(12'h901, 1'b1, 32'h4);
      fault(12'hE1A, 1'b1, 32'h7);
      fault(12'h810, 1'b0, 32'hF);
   endtask
   ////////////////////////////////////////////////////////////
   // clock, hang guard and main sequence
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   initial begin
      repeat (5000) @(posedge aclk);
      n_fail++;
      summarize();
   end
   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      {awaddr, wdata, araddr} = 96'h0;
      wstrb = 4'hF;
      awprot = 3'h0;
      arprot = 3'h0;
      crystal_ok = 1'b1;
      bus_access = '0;
      n_fail = 0;
      cmp_count = 0;
      do_reset();
      t_enable();
      t_pend();
      t_crystal();
      t_wdog();
      t_fault();
      summarize();
   end
endmodule
